/* File: hdl/watchdog_with_beeper.sv */
// watchdog timer with beeper tone generator on the special register bus
`timescale 1ns/10ps

module watchdog_with_beeper
  import wdt_tone_output_pin_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       sys_rst_i,
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic       sfr_wr_i,
  input  wire logic       sfr_rd_i,
  input  wire logic [7:0] sfr_wdata_i,
  output logic      [7:0] sfr_rdata_o,
  input  wire logic       watchdog_interrupt_enable_i,
  input  wire logic       idle_i,
  input  wire logic       power_down_i,
  input  wire logic       port4_latch_i,
  input  wire logic       port4_dir_out_i,
  output logic            watchdog_run_flag_o,
  output logic            wdt_irq_o,
  output logic            wdt_nmi_o,
  output logic            tone_output_pin_o,
  output logic            tone_output_pin_oe_o
);

  // *****************************************************************
  // register access decode
  // *****************************************************************

  logic wr_ctrl;
  logic wr_data;
  logic rd_ctrl;
  logic rd_data;

  assign wr_ctrl = sfr_wr_i && (sfr_addr_i == CTRL_ADDR);
  assign wr_data = sfr_wr_i && (sfr_addr_i == COUNT_ADDR);
  assign rd_ctrl = sfr_rd_i && (sfr_addr_i == CTRL_ADDR);
  assign rd_data = sfr_rd_i && (sfr_addr_i == COUNT_ADDR);

  // *****************************************************************
  // control and start value registers
  // *****************************************************************

  ctrl_type             ctrl_ff;
  logic [7:0]           start_ff;
  logic                 restart_ff;
  wdt_state_type        state_ff;
  logic [7:0]           count_ff;
  logic [PRESC_W-1:0]   presc_ff;
  logic                 tick;
  logic                 overflow;
  ctrl_type             ctrl_wr;

  assign ctrl_wr = ctrl_type'(sfr_wdata_i);

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      ctrl_ff <= ctrl_type'(CTRL_RESET);
    else if (wr_ctrl)
    begin
      ctrl_ff <= ctrl_wr;
      ctrl_ff.watchdog_restart_bit <= 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      start_ff <= DATA_RESET;
    else if (wr_data)
      start_ff <= sfr_wdata_i;
  end

  // restart request lives one cycle, then clears by itself
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      restart_ff <= 1'b0;
    else
      restart_ff <= wr_ctrl && sfr_wdata_i[RESTART_BIT]; // RULE_08
  end

  // *****************************************************************
  // run state: only reset returns the watchdog to stopped
  // *****************************************************************

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      state_ff <= WDT_STOPPED;
    else
    begin
      unique case (state_ff)
        WDT_STOPPED:
          if (restart_ff)
            state_ff <= WDT_COUNTING; // RULE_01
        WDT_COUNTING:
          state_ff <= WDT_COUNTING; // RULE_09
        default:
          state_ff <= WDT_STOPPED;
      endcase
    end
  end

  assign watchdog_run_flag_o = (state_ff == WDT_COUNTING);

  // *****************************************************************
  // prescaler and counter
  // *****************************************************************

  // prescaler freezes in power-down, keeps running in idle
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      presc_ff <= '0;
    else if (!power_down_i)
      presc_ff <= presc_ff + PRESC_W'(1); // RULE_10
  end

  assign tick = !power_down_i &&
                wdt_tick(ctrl_ff.watchdog_clock_select, presc_ff); // RULE_11
  assign overflow = (state_ff == WDT_COUNTING) && !restart_ff && tick &&
                    (count_ff == COUNT_MAX); // RULE_04

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      count_ff <= DATA_RESET;
    else if (restart_ff)
      count_ff <= start_ff; // RULE_02 RULE_08
    else if (overflow)
      count_ff <= start_ff; // RULE_12
    else if ((state_ff == WDT_COUNTING) && tick)
      count_ff <= count_ff + 8'h01; // RULE_01
  end

  // *****************************************************************
  // interrupt requests, one-cycle pulses
  // *****************************************************************

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      wdt_nmi_o <= 1'b0;
    else
      wdt_nmi_o <= overflow && ctrl_ff.watchdog_interrupt_type_bit; // RULE_05 RULE_06
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      wdt_irq_o <= 1'b0;
    else
      wdt_irq_o <= overflow && !ctrl_ff.watchdog_interrupt_type_bit &&
                   watchdog_interrupt_enable_i; // RULE_07
  end

  // *****************************************************************
  // read data
  // *****************************************************************

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      sfr_rdata_o <= 8'h00;
    else if (rd_ctrl)
      sfr_rdata_o <= {ctrl_ff.beeper_run_bit, ctrl_ff.tone_select,
                      restart_ff, ctrl_ff.watchdog_interrupt_type_bit,
                      ctrl_ff.watchdog_clock_select};
    else if (rd_data)
      sfr_rdata_o <= count_ff; // RULE_03
    else
      sfr_rdata_o <= 8'h00;
  end

  // *****************************************************************
  // beeper
  // *****************************************************************

  logic [TONE_OUTPUT_PIN_CNT_W-1:0] tone_output_pin_cnt_ff;
  logic                  tone_output_pin_wave_ff;
  logic                  tone_output_pin_last;

  assign tone_output_pin_last = (tone_output_pin_cnt_ff >= tone_output_pin_half_last(ctrl_ff.tone_select));

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i || !ctrl_ff.beeper_run_bit)
      tone_output_pin_cnt_ff <= '0;
    else if (tone_output_pin_last)
      tone_output_pin_cnt_ff <= '0; // RULE_14
    else
      tone_output_pin_cnt_ff <= tone_output_pin_cnt_ff + TONE_OUTPUT_PIN_CNT_W'(1);
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i || !ctrl_ff.beeper_run_bit)
      tone_output_pin_wave_ff <= 1'b0; // RULE_14
    else if (tone_output_pin_last)
      tone_output_pin_wave_ff <= !tone_output_pin_wave_ff; // RULE_13
  end

  // alternate function: tone gated by the port latch set to 1
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      tone_output_pin_o <= 1'b1;
    else if (ctrl_ff.beeper_run_bit)
      tone_output_pin_o <= tone_output_pin_wave_ff && port4_latch_i; // RULE_15 RULE_16
    else
      tone_output_pin_o <= port4_latch_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      tone_output_pin_oe_o <= 1'b0;
    else
      tone_output_pin_oe_o <= port4_dir_out_i; // RULE_16
  end

  // *****************************************************************
  // assertions
  // *****************************************************************

  default clocking cb @(posedge clk_i);
  endclocking

  default disable iff (sys_rst_i);

  sequence s_restart_write;
    wr_ctrl && sfr_wdata_i[RESTART_BIT];
  endsequence

  sequence s_reload_done;
    restart_ff ##1 (!restart_ff && count_ff == $past(start_ff));
  endsequence

  property p_restart;
    s_restart_write |=> s_reload_done;
  endproperty
  a_restart: assert property (p_restart) // RULE_08
    else $error("restart did not reload the start value");

  property p_start_runs;
    s_restart_write |=> ##1 (state_ff == WDT_COUNTING);
  endproperty
  a_start_runs: assert property (p_start_runs) // RULE_01
    else $error("watchdog did not start");

  property p_never_stops;
    (state_ff == WDT_COUNTING) |=> (state_ff == WDT_COUNTING);
  endproperty
  a_never_stops: assert property (p_never_stops) // RULE_09
    else $error("running watchdog stopped");

  property p_overflow_reload;
    overflow |=> (count_ff == $past(start_ff));
  endproperty
  a_overflow_reload: assert property (p_overflow_reload) // RULE_12
    else $error("counter not reloaded after overflow");

  property p_nmi_select;
    overflow && ctrl_ff.watchdog_interrupt_type_bit |=> wdt_nmi_o && !wdt_irq_o;
  endproperty
  a_nmi_select: assert property (p_nmi_select) // RULE_06
    else $error("non-maskable overflow not signalled");

  property p_irq_cause;
    wdt_irq_o |-> $past(overflow) && !$past(ctrl_ff.watchdog_interrupt_type_bit)
                  && $past(watchdog_interrupt_enable_i);
  endproperty
  a_irq_cause: assert property (p_irq_cause) // RULE_07
    else $error("maskable interrupt without enabled overflow");

  property p_power_down_hold;
    power_down_i && !restart_ff |=> $stable(count_ff);
  endproperty
  a_power_down_hold: assert property (p_power_down_hold) // RULE_10
    else $error("counter moved in power-down");

  property p_fast_count;
    (state_ff == WDT_COUNTING) && !restart_ff && !power_down_i &&
    (ctrl_ff.watchdog_clock_select == 3'h0) && (count_ff != COUNT_MAX)
    |=> count_ff == $past(count_ff) + 8'h01;
  endproperty
  a_fast_count: assert property (p_fast_count) // RULE_11
    else $error("undivided clock did not advance the counter");

  property p_read_count;
    rd_data |=> sfr_rdata_o == $past(count_ff);
  endproperty
  a_read_count: assert property (p_read_count) // RULE_03
    else $error("data register read not the count");

  property p_tone_output_pin_off;
    !ctrl_ff.beeper_run_bit |=> !tone_output_pin_wave_ff;
  endproperty
  a_tone_output_pin_off: assert property (p_tone_output_pin_off) // RULE_14
    else $error("tone running while beeper stopped");

  property p_tone_output_pin_hold;
    ctrl_ff.beeper_run_bit && !tone_output_pin_last && !wr_ctrl |=> $stable(tone_output_pin_wave_ff);
  endproperty
  a_tone_output_pin_hold: assert property (p_tone_output_pin_hold) // RULE_13
    else $error("tone toggled before half period");

endmodule : watchdog_with_beeper

/* File: pkg/wdt_tone_output_pin_pkg.sv */
// constants, types and helpers for the watchdog timer and beeper block
// *****************************************************************
// Notes on behaviour
// RULE_01: Setting the run flag starts an 8-bit up-counter that advances once per selected counting-clock tick.
// RULE_02: The counter takes its starting value from the data register when counting begins.
// RULE_03: The data register reads back the current eight-bit count.
// RULE_04: An overflow past 8'hff of the running counter raises a watchdog interrupt request.
// RULE_05: Control bit 3 chooses whether the overflow interrupt is maskable or non-maskable.
// RULE_06: A 1 in the interrupt-type bit selects the non-maskable interrupt, a 0 the maskable one.
// RULE_07: A maskable watchdog interrupt is suppressed while the external watchdog enable bit is 0.
// RULE_08: Writing 1 to control bit 4 reloads the counter from the start value and the bit then clears itself.
// RULE_09: Once counting, writing 1 to the run or restart bit never stops the counter, it only restarts it.
// RULE_10: The counter keeps running in idle mode and halts in power-down mode.
// RULE_11: Clock select 000 counts every system clock, 001 to 111 divide by 2^3,2^4,2^5,2^7,2^9,2^11,2^13.
// RULE_12: After an overflow the counter reloads the start value and keeps counting, interrupting again on each overflow.
// RULE_13: The beeper produces a square wave at one of four tones.
// RULE_14: Tone codes 00,01,10,11 divide the oscillator clock by 6000,3000,1600,900, sounding only while bit 7 is 1.
// RULE_15: The square wave leaves on the port 4 bit 7 pin as its alternate function.
// RULE_16: Software picks the tone, then sets the pin latch to 1, then sets the pin direction to output.
// *****************************************************************
package wdt_tone_output_pin_pkg;

  localparam logic [7:0] CTRL_ADDR  = 8'hf8;
  localparam logic [7:0] COUNT_ADDR = 8'hf9;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] COUNT_MAX  = 8'hff;
  localparam int         RESTART_BIT = 4;
  localparam int         PRESC_W    = 13;
  localparam int         TONE_OUTPUT_PIN_CNT_W = 12;

  localparam int WDT_EXP [8] = '{0, 3, 4, 5, 7, 9, 11, 13};
  localparam int TONE_OUTPUT_PIN_DIV [4] = '{6000, 3000, 1600, 900};

  // control register layout, msb first
  typedef struct packed {
    logic       beeper_run_bit;
    logic [1:0] tone_select;
    logic       watchdog_restart_bit;
    logic       watchdog_interrupt_type_bit;
    logic [2:0] watchdog_clock_select;
  } ctrl_type;

  typedef enum logic [1:0] {
    WDT_STOPPED  = 2'b01,
    WDT_COUNTING = 2'b10
  } wdt_state_type;

  // one counting tick when the low prescaler bits are all ones
  function automatic logic wdt_tick(input logic [2:0] sel,
                                    input logic [PRESC_W-1:0] presc);
    logic [PRESC_W:0]   one;
    logic [PRESC_W-1:0] mask;
    one  = (PRESC_W+1)'(1) << WDT_EXP[sel];
    mask = PRESC_W'(one - (PRESC_W+1)'(1));
    return (presc & mask) == mask;
  endfunction : wdt_tick

  // last count of a half tone period
  function automatic logic [TONE_OUTPUT_PIN_CNT_W-1:0] tone_output_pin_half_last(
    input logic [1:0] tone);
    return TONE_OUTPUT_PIN_CNT_W'(TONE_OUTPUT_PIN_DIV[tone] / 2 - 1);
  endfunction : tone_output_pin_half_last

endpackage : wdt_tone_output_pin_pkg

/* File: tb/testbench.sv */
// self-checking bench for the watchdog timer and beeper block
`timescale 1ns/10ps

module testbench;
  import wdt_tone_output_pin_pkg::*;

  typedef struct {
    logic [2:0] sel;
    logic [7:0] start;
    logic       nmi;
  } row_type;

  logic       clk_i;
  logic       sys_rst_i;
  logic [7:0] sfr_addr_i;
  logic       sfr_wr_i;
  logic       sfr_rd_i;
  logic [7:0] sfr_wdata_i;
  logic [7:0] sfr_rdata_o;
  logic       watchdog_interrupt_enable_i;
  logic       idle_i;
  logic       power_down_i;
  logic       port4_latch_i;
  logic       port4_dir_out_i;
  logic       watchdog_run_flag_o;
  logic       wdt_irq_o;
  logic       wdt_nmi_o;
  logic       tone_output_pin_o;
  logic       tone_output_pin_oe_o;
  int         fails;
  int         samples_checked;
  int         cycles;
  int         n;
  int         exp_n;
  logic [7:0] a;
  logic [7:0] b;
  row_type    rows [8] = '{'{3'h0, 8'hf0, 1'b1}, '{3'h1, 8'hfe, 1'b0},
                           '{3'h2, 8'hfe, 1'b1}, '{3'h3, 8'hfe, 1'b0},
                           '{3'h4, 8'hfe, 1'b1}, '{3'h5, 8'hfe, 1'b0},
                           '{3'h6, 8'hfe, 1'b1}, '{3'h7, 8'hfe, 1'b0}};

  watchdog_with_beeper DUT (
    .clk_i                       (clk_i),
    .sys_rst_i                   (sys_rst_i),
    .sfr_addr_i                  (sfr_addr_i),
    .sfr_wr_i                    (sfr_wr_i),
    .sfr_rd_i                    (sfr_rd_i),
    .sfr_wdata_i                 (sfr_wdata_i),
    .sfr_rdata_o                 (sfr_rdata_o),
    .watchdog_interrupt_enable_i (watchdog_interrupt_enable_i),
    .idle_i                      (idle_i),
    .power_down_i                (power_down_i),
    .port4_latch_i               (port4_latch_i),
    .port4_dir_out_i             (port4_dir_out_i),
    .watchdog_run_flag_o         (watchdog_run_flag_o),
    .wdt_irq_o                   (wdt_irq_o),
    .wdt_nmi_o                   (wdt_nmi_o),
    .tone_output_pin_o           (tone_output_pin_o),
    .tone_output_pin_oe_o        (tone_output_pin_oe_o)
  );

  initial
  begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test();
    $display("fails %0d samples_checked %0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test

  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    sfr_addr_i = ad;
    sfr_wdata_i = d;
    sfr_wr_i = 1'b1;
    @(posedge clk_i);
    #1;
    sfr_wr_i = 1'b0;
    // idle edge so a following call never re-raises the strobe at once
    @(posedge clk_i);
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] ad, output logic [7:0] d);
    sfr_addr_i = ad;
    sfr_rd_i = 1'b1;
    @(posedge clk_i);
    #1;
    sfr_rd_i = 1'b0;
    d = sfr_rdata_o;
    // idle edge so a following call never re-raises the strobe at once
    @(posedge clk_i);
    #1;
  endtask : rd

  // cycles until an interrupt pulse, or lim when none came
  task automatic wait_pulse(input int lim, output int k);
    k = 0;
    do
    begin
      @(posedge clk_i);
      #1;
      k++;
    end while (k < lim && (wdt_irq_o | wdt_nmi_o) !== 1'b1);
  endtask : wait_pulse

  task automatic wait_toggle(output int k);
    logic p;
    p = tone_output_pin_o;
    k = 0;
    do
    begin
      @(posedge clk_i);
      #1;
      k++;
    end while (k < 7000 && tone_output_pin_o === p);
  endtask : wait_toggle

  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 95000)
    begin
      fails++;
      end_of_test();
    end
  end

  // ****************************************************************
  // stimulus
  // ****************************************************************
  initial
  begin
    {sfr_addr_i, sfr_wr_i, sfr_rd_i, sfr_wdata_i, idle_i} = '0;
    {watchdog_interrupt_enable_i, power_down_i, port4_dir_out_i} = '0;
    port4_latch_i = 1'b1;
    sys_rst_i = 1'b1;
    repeat (8) @(posedge clk_i);
    #1;
    sys_rst_i = 1'b0;
    foreach (rows[i])
    begin
      watchdog_interrupt_enable_i = !rows[i].nmi;
      idle_i = i[0];
      wr(COUNT_ADDR, rows[i].start);
      wr(CTRL_ADDR, {4'h1, rows[i].nmi, rows[i].sel});
      exp_n = (256 - rows[i].start) << WDT_EXP[rows[i].sel];
      wait_pulse(2 * exp_n + 8, n);
      check(wdt_nmi_o, rows[i].nmi);
      check(wdt_irq_o, !rows[i].nmi);
      wait_pulse(2 * exp_n, n);
      check(n, exp_n);
      check(watchdog_run_flag_o, 1'b1);
    end
    idle_i = 1'b0;
    wr(COUNT_ADDR, 8'hf8);
    repeat (12)
    begin
      wr(CTRL_ADDR, 8'h18);
      wait_pulse(4, n);
      check(n, 4);
      check(watchdog_run_flag_o, 1'b1);
    end
    rd(CTRL_ADDR, a);
    check(a, 8'h08);
    wr(COUNT_ADDR, 8'h10);
    wr(CTRL_ADDR, 8'h18);
    repeat (3) @(posedge clk_i);
    #1;
    rd(COUNT_ADDR, a);
    rd(COUNT_ADDR, b);
    check(8'(b - a), 8'h02);
    check(a - 8'h10 < 8'h08, 1'b1);
    power_down_i = 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    rd(COUNT_ADDR, a);
    wait_pulse(300, n);
    check(n, 300);
    rd(COUNT_ADDR, b);
    check(b, a);
    power_down_i = 1'b0;
    wait_pulse(300, n);
    check(n < 260, 1'b1);
    watchdog_interrupt_enable_i = 1'b0;
    wr(COUNT_ADDR, 8'hf0);
    wr(CTRL_ADDR, 8'h10);
    wait_pulse(40, n);
    check(n, 40);
    watchdog_interrupt_enable_i = 1'b1;
    wait_pulse(20, n);
    check(wdt_irq_o, 1'b1);
    wr(8'hf7, 8'hff);
    rd(8'hf7, a);
    check(a, 8'h00);
    rd(CTRL_ADDR, a);
    check(a, 8'h00);
    for (int t = 0; t < 4; t++)
    begin
      wr(CTRL_ADDR, {1'b1, 2'(t), 5'h00});
      port4_latch_i = 1'b1;
      port4_dir_out_i = 1'b1;
      wait_toggle(n);
      wait_toggle(n);
      check(n, TONE_OUTPUT_PIN_DIV[t] / 2);
      check(tone_output_pin_oe_o, 1'b1);
    end
    port4_latch_i = 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    check(tone_output_pin_o, 1'b0);
    wr(CTRL_ADDR, 8'h60);
    port4_latch_i = 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
    check(tone_output_pin_o, 1'b1);
    wait_toggle(n);
    check(n, 7000);
    sys_rst_i = 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    check(tone_output_pin_oe_o, 1'b0);
    sys_rst_i = 1'b0;
    port4_dir_out_i = 1'b0;
    check({watchdog_run_flag_o, wdt_irq_o, wdt_nmi_o}, 3'b000);
    rd(CTRL_ADDR, a);
    check(a, 8'h00);
    rd(COUNT_ADDR, a);
    check(a, 8'h00);
    wait_pulse(300, n);
    check(n, 300);
    check(watchdog_run_flag_o, 1'b0);
    end_of_test();
  end

endmodule : testbench
